// >>> hdl/pdc_pin_cell.v
// One pin's output driver, enable and weak pullup control
`timescale 1ns/100ps

module pdc_pin_cell (
   input  wire clk,            // System clock
   input  wire srst,           // Synchronous reset, active high
   input  wire dir_bit,        // 1 = output, 0 = input
   input  wire out_bit,        // Port output value bit
   output reg  pin_o,          // Value driven on the pin
   output reg  pin_oe,         // High while the pin is driven
   output reg  pullup_en       // High while the weak pullup is on
);

   // ==================================================
   // Pin drive registers
   // Registered so the top's pin outputs come straight from flops
   always @(posedge clk) begin
      if (srst) begin
         pin_o     <= 1'b0;
         pin_oe    <= 1'b0;
         pullup_en <= 1'b0;
      end else begin
         pin_o     <= dir_bit & out_bit;
         pin_oe    <= dir_bit;
         pullup_en <= ~dir_bit & out_bit;
      end
   end

endmodule // pdc_pin_cell

// >>> hdl/pdc_port.v
// One port: a row of pin cells built by a generate loop
`timescale 1ns/100ps

module pdc_port #(
   parameter WIDTH = 8         // Pins on this port
) (
   input  wire             clk,        // System clock
   input  wire             srst,       // Synchronous reset
   input  wire [WIDTH-1:0] dir_bits,   // Direction register
   input  wire [WIDTH-1:0] out_bits,   // Output value register
   output wire [WIDTH-1:0] pin_o,      // Pin output values
   output wire [WIDTH-1:0] pin_oe,     // Pin output enables
   output wire [WIDTH-1:0] pullup_en   // Weak pullup enables
);

   // ==================================================
   // Per-pin cells; each pin is controlled independently
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
         pdc_pin_cell u_cell (
            .clk       (clk),
            .srst      (srst),
            .dir_bit   (dir_bits[g]),
            .out_bit   (out_bits[g]),
            .pin_o     (pin_o[g]),
            .pin_oe    (pin_oe[g]),
            .pullup_en (pullup_en[g])
         );
      end
   endgenerate

endmodule // pdc_port

// >>> hdl/pdc_top.v
// Port direction control: Avalon-MM registers and two GPIO ports
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "pdc_consts.vh"

// Functional notes
// - All resets clear both direction registers
// - Port 0 bit one drives output value
// - Direction zero makes pin an input
// - Input with output one enables pullup
// - Input with output zero is three-state
// - Port 1 has seven direction bits
// - Port 1 direction bit 7 reads zero
module pdc_top (
   input  wire        clk,               // System clock, 50 MHz
   input  wire        srst,              // Synchronous reset, active high
   input  wire [9:0]  avs_address,       // Byte address
   input  wire        avs_read,          // Read request
   input  wire        avs_write,         // Write request
   input  wire [31:0] avs_writedata,     // Write data
   input  wire [3:0]  avs_byteenable,    // Byte lanes
   output reg  [31:0] avs_readdata,      // Read data
   output reg         avs_waitrequest,   // Stall, high until answered
   output wire [7:0]  port0_pin_o,       // Port 0 driven values
   output wire [7:0]  port0_pin_oe,      // Port 0 output enables
   output wire [7:0]  port0_pullup_en,   // Port 0 weak pullups
   output wire [6:0]  port1_pin_o,       // Port 1 driven values
   output wire [6:0]  port1_pin_oe,      // Port 1 output enables
   output wire [6:0]  port1_pullup_en    // Port 1 weak pullups
);

   // ==================================================
   // Register storage
   reg  [7:0] port0_pin_direction_q;     // Port 0 direction
   reg  [6:0] port1_pin_direction_q;     // Port 1 direction, bit 7 absent
   reg  [7:0] port0_output_value_q;      // Port 0 output value
   reg  [6:0] port1_output_value_q;      // Port 1 output value
   reg        done_q;                    // Access answered this cycle
   wire       req;                       // A request is pending
   wire       wr_en;                     // Write commits this cycle
   reg  [31:0] rd_d;                     // Read data next value

   assign req   = (avs_read | avs_write) & ~done_q;
   // Write commits only at the edge where the master sees waitrequest low
   assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];

   // ==================================================
   // Bus handshake
   // One wait state: waitrequest falls the cycle after the request rises,
   // then a cycle of rest so a held request is not taken twice.
   always @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         done_q          <= 1'b0;
      end else begin
         avs_waitrequest <= ~req;
         done_q          <= req;
      end
   end

   // ==================================================
   // Register writes
   always @(posedge clk) begin
      if (srst) begin
         port0_pin_direction_q <= `PDC_DIR_RESET;
         port1_pin_direction_q <= `PDC_P1_RESET;
         port0_output_value_q  <= `PDC_OUT_RESET;
         port1_output_value_q  <= `PDC_P1_RESET;
      end else if (wr_en) begin
         case (avs_address)
            `PDC_ADDR_PORT0_DIR: begin
               port0_pin_direction_q <= avs_writedata[7:0];
            end
            `PDC_ADDR_PORT1_DIR: begin
               port1_pin_direction_q <= avs_writedata[6:0];
            end
            `PDC_ADDR_PORT0_OUT: begin
               port0_output_value_q  <= avs_writedata[7:0];
            end
            `PDC_ADDR_PORT1_OUT: begin
               port1_output_value_q  <= avs_writedata[6:0];
            end
            default: begin
               // Unmapped writes are accepted and dropped
            end
         endcase
      end
   end

   // ==================================================
   // Read mux
   always @* begin
      rd_d = `PDC_UNMAPPED_READ;
      case (avs_address)
         `PDC_ADDR_PORT0_DIR: begin
            rd_d = {24'h000000, port0_pin_direction_q};
         end
         `PDC_ADDR_PORT1_DIR: begin
            rd_d = {25'h0000000, port1_pin_direction_q};
         end
         `PDC_ADDR_PORT0_OUT: begin
            rd_d = {24'h000000, port0_output_value_q};
         end
         `PDC_ADDR_PORT1_OUT: begin
            rd_d = {25'h0000000, port1_output_value_q};
         end
         default: begin
            rd_d = `PDC_UNMAPPED_READ;
         end
      endcase
   end

   // Read data registered together with the falling waitrequest
   always @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~done_q) begin
         avs_readdata <= rd_d;
      end
   end

   // ==================================================
   // Pin control for both ports
   // port 0 pins
   pdc_port #(.WIDTH(`PDC_P0_WIDTH)) u_port0 (
      .clk       (clk),
      .srst      (srst),
      .dir_bits  (port0_pin_direction_q),
      .out_bits  (port0_output_value_q),
      .pin_o     (port0_pin_o),
      .pin_oe    (port0_pin_oe),
      .pullup_en (port0_pullup_en)
   );

   pdc_port #(.WIDTH(`PDC_P1_WIDTH)) u_port1 (
      .clk       (clk),
      .srst      (srst),
      .dir_bits  (port1_pin_direction_q),
      .out_bits  (port1_output_value_q),
      .pin_o     (port1_pin_o),
      .pin_oe    (port1_pin_oe),
      .pullup_en (port1_pullup_en)
   );

endmodule // pdc_top

// >>> pkg/pdc_consts.vh
// Constants for the port direction control block
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// ==================================================
// Register offsets (register indices; byte address = index * 4)
`define PDC_IDX_PORT0_DIR     8'h08
`define PDC_IDX_PORT1_DIR     8'h09
`define PDC_IDX_PORT0_OUT     8'h0a
`define PDC_IDX_PORT1_OUT     8'h0b
`define PDC_ADDR_PORT0_DIR    10'h020
`define PDC_ADDR_PORT1_DIR    10'h024
`define PDC_ADDR_PORT0_OUT    10'h028
`define PDC_ADDR_PORT1_OUT    10'h02c

// ==================================================
// Field layout and reset values
`define PDC_P0_WIDTH          8
`define PDC_P1_WIDTH          7
`define PDC_P1_USED_MASK      8'h7f
`define PDC_DIR_RESET         8'h00
`define PDC_OUT_RESET         8'h00
`define PDC_P1_RESET          7'h00
`define PDC_UNMAPPED_READ     32'h00000000

`endif

// >>> test/pdc_chk.sv
// Checker of the port direction bus handshake and pin outputs
`timescale 1ns/100ps
module pdc_chk (
   input wire        clk, srst, avs_read, avs_write, avs_waitrequest,
   input wire [9:0]  avs_address,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_writedata, avs_readdata,
   input wire [7:0]  port0_pin_o, port0_pin_oe, port0_pullup_en,
   input wire [6:0]  port1_pin_o, port1_pin_oe, port1_pullup_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Write taken with lane 0 on; pins follow two edges on
   wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   chk_reset_clear: assert property (
      $fell(srst) |-> {port0_pin_oe, port1_pin_oe, port0_pullup_en, port1_pullup_en} == 30'h0)
      else $error("pins not cleared by reset");
   chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   chk_answer_next: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   chk_p0_dir: assert property (
      wr_ok && avs_address == 10'h020 |=> ##1 port0_pin_oe == $past(avs_writedata[7:0], 2))
      else $error("port0 direction");
   chk_p1_dir: assert property (
      wr_ok && avs_address == 10'h024 |=> ##1 port1_pin_oe == $past(avs_writedata[6:0], 2))
      else $error("port1 direction");
   chk_out_value: assert property (
      wr_ok && avs_address == 10'h028 |=> ##1
      (port0_pin_o | port0_pullup_en) == $past(avs_writedata[7:0], 2)) else $error("out value");
   chk_input_quiet: assert property (
      (port0_pin_o & ~port0_pin_oe) == 8'h0 && (port1_pin_o & ~port1_pin_oe) == 7'h0)
      else $error("input pin driven");
   chk_pullup_input: assert property (
      (port0_pullup_en & port0_pin_oe) == 8'h0 && (port1_pullup_en & port1_pin_oe) == 7'h0)
      else $error("pullup on output");
   chk_p1_top_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == 10'h024 |-> avs_readdata[31:7] == 25'h0)
      else $error("port1 bit 7 set");
endmodule // pdc_chk
bind pdc_top pdc_chk i_chk (.*);

// >>> test/pdc_pin_env.sv
// Pin-side circuit: outside drivers, pullups and floating lines
`timescale 1ns/100ps
module pdc_pin_env #(parameter W = 8) (
   input  wire         clk,
   input  wire [W-1:0] pin_o, pin_oe, pullup_en, ext_en, ext_v,
   output wire [W-1:0] level
);
   // Floating lines flip each cycle so stale levels never pass
   reg [W-1:0] flt_q = {W{1'b0}};
   always @(posedge clk) begin
      flt_q <= ~flt_q;
   end
   assign level = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v) |
                  (~pin_oe & ~ext_en & (pullup_en | flt_q));
endmodule // pdc_pin_env

// >>> test/tb_port_direction_control.sv
// Testbench of the port direction control block
`timescale 1ns/100ps
module tb_port_direction_control;
   reg         clk = 0, srst = 1, avs_read = 0, avs_write = 0;
   reg [9:0]   avs_address = 0;
   reg [31:0]  avs_writedata = 0, q;
   reg [3:0]   avs_byteenable = 0;
   reg [7:0]   x_en = 0, x_v = 0, d0, o0, d1, o1;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire [7:0]  port0_pin_o, port0_pin_oe, port0_pullup_en, lvl;
   wire [6:0]  port1_pin_o, port1_pin_oe, port1_pullup_en;
   integer     mismatches = 0, comparisons = 0, seed = 32'h25e3ae43, cyc = 0, i;
   initial forever #10 clk = ~clk;
   pdc_top i_dut (.*);
   pdc_pin_env i_env (.clk(clk), .pin_o(port0_pin_o), .pin_oe(port0_pin_oe),
      .pullup_en(port0_pullup_en), .ext_en(x_en), .ext_v(x_v), .level(lvl));
   task tally_and_finish;
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard, far above the run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         tally_and_finish;
      end
   end
   task chk(input [31:0] g, input [31:0] e);
      comparisons = comparisons + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Avalon cycle: hold until waitrequest is seen low
   task bus(input [9:0] a, input w, input [7:0] d, input [3:0] b);
      @(posedge clk);
      avs_address <= a; avs_write <= w; avs_read <= !w;
      avs_writedata <= {24'h0, d}; avs_byteenable <= b;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0; avs_write <= 0;
   endtask
   // Expected wire level; floating bits come out zero
   function [7:0] want(input [7:0] d, o, e, v);
      want = (d & o) | (~d & e & v) | (~d & ~e & o);
   endfunction
   initial begin
      repeat (8) @(posedge clk);
      srst <= 0;
      bus(10'h024, 0, 0, 1); chk(q, 0);
      for (i = 0; i < 24; i = i + 1) begin
         d0 = $random(seed); o0 = $random(seed); d1 = $random(seed); o1 = $random(seed);
         x_en <= $random(seed); x_v <= $random(seed);
         if (i < 2) begin
            d0 = i ? 8'h00 : 8'hff; o0 = i ? 8'hff : 8'ha5; d1 = {i[0], 7'h7f};
         end
         bus(10'h028, 1, o0, 1); bus(10'h02c, 1, o1, 1);
         bus(10'h020, 1, d0, 1); bus(10'h024, 1, d1, 1);
         bus(10'h024, 0, 0, 0); chk(q, {25'h0, d1[6:0]});
         bus(10'h020, 0, 0, 0); chk(q, {24'h0, d0});
         chk({port0_pin_oe, port0_pin_o, port0_pullup_en}, {d0, d0 & o0, ~d0 & o0});
         chk({port1_pin_oe, port1_pin_o, port1_pullup_en},
             {d1[6:0], d1[6:0] & o1[6:0], ~d1[6:0] & o1[6:0]});
         chk(lvl & (d0 | x_en | o0), want(d0, o0, x_en, x_v));
      end
      // Lane 0 off and unmapped places drop writes
      bus(10'h020, 1, ~d0, 0); bus(10'h3fc, 1, 8'hff, 1);
      bus(10'h3fc, 0, 0, 1); chk(q, 0);
      bus(10'h020, 0, 0, 1); chk(q, {24'h0, d0});
      bus(10'h028, 0, 0, 0); chk(q, {24'h0, o0});
      bus(10'h02c, 0, 0, 0); chk(q, {25'h0, o1[6:0]});
      srst <= 1;
      repeat (2) @(posedge clk);
      srst <= 0;
      bus(10'h020, 0, 0, 1); chk({q[7:0], port0_pin_oe, port1_pin_oe}, 0);
      tally_and_finish;
   end
endmodule // tb_port_direction_control
